/* File: design/apc_pkg.sv */
// Notes on behaviour
// - Under-voltage select bit 7 low enables the supply detector, high disables it.
// - Enabled detector with supply below trip level fades audio, then drive off.
// - Trip code 0..5 gives 4/8.2/9.7/13.2/15.5/19.5 V; others mean 4 V.
// - Bit 5 over-supply, bit 6 low-supply: 0 fades, 1 cuts at once; the under-voltage cut here always fades first, whatever bit 6 holds.
// - State control 4 holds per-channel mix, clip, limit enables; 1 enables.
// - State control 4 bit 3: 0 stereo, 1 mono output.
// - Attack rate code is upper nibble of rate register, 3 to 0.0451 dB/ms.
// - Release rate code is lower nibble, 0.5106 to 0.0104 dB/ms.
// - Input above attack threshold lowers gain at attack rate.
// - Attack threshold is 24 bits from 0x10 top, 0x11 middle, 0x12 bottom.
// - Threshold 0x200000 means 0 dB.
// - Clip level is 24 bits from 0x13 top to 0x15 bottom; 0x200000 is 0 dB.
// - Levels are unsigned 3.21 fixed point; 0x200000 is unity.
package apc_pkg;
    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] APC_ADDR_UV    = 8'h06;
    localparam logic [7:0] APC_ADDR_SC4   = 8'h07;
    localparam logic [7:0] APC_ADDR_RATE  = 8'h08;
    localparam logic [7:0] APC_ADDR_THR_T = 8'h10;
    localparam logic [7:0] APC_ADDR_THR_M = 8'h11;
    localparam logic [7:0] APC_ADDR_THR_B = 8'h12;
    localparam logic [7:0] APC_ADDR_CLP_T = 8'h13;
    localparam logic [7:0] APC_ADDR_CLP_M = 8'h14;
    localparam logic [7:0] APC_ADDR_CLP_B = 8'h15;
    // ********************************
    // Field positions
    // ********************************
    localparam int APC_UV_DIS_BIT    = 7;
    localparam int APC_LV_NOFADE_BIT = 6;
    localparam int APC_OV_NOFADE_BIT = 5;
    localparam int APC_SC4_MIX1_BIT  = 7;
    localparam int APC_SC4_MIX2_BIT  = 6;
    localparam int APC_SC4_CLIP1_BIT = 5;
    localparam int APC_SC4_LIM1_BIT  = 4;
    localparam int APC_SC4_MONO_BIT  = 3;
    localparam int APC_SC4_CLIP2_BIT = 2;
    localparam int APC_SC4_LIM2_BIT  = 1;
    // ********************************
    // Reset values and masks
    // ********************************
    localparam logic [7:0]  APC_UV_RST    = 8'h00;
    localparam logic [7:0]  APC_UV_MASK   = 8'hE7;
    localparam logic [7:0]  APC_SC4_RST   = 8'h00;
    localparam logic [7:0]  APC_SC4_MASK  = 8'hFE;
    localparam logic [7:0]  APC_RATE_RST  = 8'h00;
    localparam logic [23:0] APC_UNITY     = 24'h200000;
    // Last fade count before the drive is cut
    localparam logic [3:0]  APC_FADE_LAST = 4'hF;
    // Trip levels in millivolts
    localparam logic [15:0] APC_TRIP_MV0  = 16'h0FA0;
    localparam logic [15:0] APC_TRIP_MV1  = 16'h2008;
    localparam logic [15:0] APC_TRIP_MV2  = 16'h25E4;
    localparam logic [15:0] APC_TRIP_MV3  = 16'h3390;
    localparam logic [15:0] APC_TRIP_MV4  = 16'h3C8C;
    localparam logic [15:0] APC_TRIP_MV5  = 16'h4C2C;
endpackage

/* File: design/apc_lvl_if.sv */
`timescale 1ns/1ps
// Coherent 24-bit level update between register bank and shadow
interface apc_lvl_if;
    logic        wr;
    logic [1:0]  sel;
    logic [7:0]  data;
    logic [23:0] level;
    modport bank   (output wr, output sel, output data, input level);
    modport shadow (input wr, input sel, input data, output level);
endinterface

/* File: design/apc_level_shadow.sv */
`timescale 1ns/1ps
// Staged 24-bit level: bytes gather, bottom byte commits all three
module apc_level_shadow
    import apc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_b,
    apc_lvl_if.shadow lv
);
    logic [7:0]  hi_reg;
    logic [7:0]  mid_reg;
    logic [23:0] level_reg;

    // ********************************
    // Staging and commit
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hi_reg    <= APC_UNITY[23:16];
            mid_reg   <= APC_UNITY[15:8];
            level_reg <= APC_UNITY;
        end else if (lv.wr) begin
            if (lv.sel == 2'h0) begin
                hi_reg <= lv.data;
            end else if (lv.sel == 2'h1) begin
                mid_reg <= lv.data;
            end else begin
                level_reg <= {hi_reg, mid_reg, lv.data};
            end
        end
    end

    assign lv.level = level_reg;
endmodule

/* File: design/apc_regs.sv */
`timescale 1ns/1ps
module apc_regs
    import apc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             power_stage_uv_enable,
    output logic      [15:0] power_stage_trip_mv,
    output logic             power_stage_uv_cut,
    output logic             low_supply_fade_off,
    output logic             over_supply_fade_off,
    output logic             ch1_mix_enable,
    output logic             ch2_mix_enable,
    output logic             ch1_clip_enable,
    output logic             ch2_clip_enable,
    output logic             ch1_power_limit_enable,
    output logic             ch2_power_limit_enable,
    output logic             mono_select,
    output logic      [3:0]  drc_attack_rate_code,
    output logic      [3:0]  drc_release_rate_code,
    output logic      [23:0] drc_threshold,
    output logic      [23:0] clip_level,
    output logic             drc_attack_active,
    input  wire logic        power_stage_below_trip,
    input  wire logic        input_rms_above
);
    typedef enum logic [2:0] {
        APC_UV_IDLE = 3'b001,
        APC_UV_FADE = 3'b010,
        APC_UV_OFF  = 3'b100
    } apc_uv_state_t;

    logic [7:0]    hv_undervoltage_select_reg;
    logic [7:0]    state_control_four_reg;
    logic [7:0]    drc_attack_release_rate_reg;
    logic [7:0]    rdata_next;
    logic [15:0]   trip_next;
    apc_uv_state_t uv_state_reg;
    logic [3:0]    fade_cnt_reg;
    logic          below_s1_reg;
    logic          below_s2_reg;
    logic          rms_s1_reg;
    logic          rms_s2_reg;
    logic [7:0]    thr_t_reg;
    logic [7:0]    thr_m_reg;
    logic [7:0]    thr_b_reg;
    logic [7:0]    clp_t_reg;
    logic [7:0]    clp_m_reg;
    logic [7:0]    clp_b_reg;

    apc_lvl_if thr_if ();
    apc_lvl_if clp_if ();

    // ********************************
    // Trip level decode
    // ********************************
    function automatic logic [15:0] trip_mv(input logic [2:0] code);
        case (code)
            3'h1:    trip_mv = APC_TRIP_MV1;
            3'h2:    trip_mv = APC_TRIP_MV2;
            3'h3:    trip_mv = APC_TRIP_MV3;
            3'h4:    trip_mv = APC_TRIP_MV4;
            3'h5:    trip_mv = APC_TRIP_MV5;
            default: trip_mv = APC_TRIP_MV0;
        endcase
    endfunction

    // ********************************
    // Control registers
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hv_undervoltage_select_reg  <= APC_UV_RST;
            state_control_four_reg      <= APC_SC4_RST;
            drc_attack_release_rate_reg <= APC_RATE_RST;
        end else if (reg_wr) begin
            if (reg_addr == APC_ADDR_UV) begin
                hv_undervoltage_select_reg <= reg_wdata & APC_UV_MASK;
            end else if (reg_addr == APC_ADDR_SC4) begin
                state_control_four_reg <= reg_wdata & APC_SC4_MASK;
            end else if (reg_addr == APC_ADDR_RATE) begin
                drc_attack_release_rate_reg <= reg_wdata;
            end
        end
    end

    // Level byte readback copies
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            thr_t_reg <= APC_UNITY[23:16];
            thr_m_reg <= APC_UNITY[15:8];
            thr_b_reg <= APC_UNITY[7:0];
            clp_t_reg <= APC_UNITY[23:16];
            clp_m_reg <= APC_UNITY[15:8];
            clp_b_reg <= APC_UNITY[7:0];
        end else if (reg_wr) begin
            if (reg_addr == APC_ADDR_THR_T) begin
                thr_t_reg <= reg_wdata;
            end else if (reg_addr == APC_ADDR_THR_M) begin
                thr_m_reg <= reg_wdata;
            end else if (reg_addr == APC_ADDR_THR_B) begin
                thr_b_reg <= reg_wdata;
            end else if (reg_addr == APC_ADDR_CLP_T) begin
                clp_t_reg <= reg_wdata;
            end else if (reg_addr == APC_ADDR_CLP_M) begin
                clp_m_reg <= reg_wdata;
            end else if (reg_addr == APC_ADDR_CLP_B) begin
                clp_b_reg <= reg_wdata;
            end
        end
    end

    // ********************************
    // Coherent 24-bit levels
    // ********************************
    always_comb begin
        thr_if.wr   = reg_wr && (reg_addr >= APC_ADDR_THR_T) && (reg_addr <= APC_ADDR_THR_B);
        thr_if.sel  = 2'(reg_addr - APC_ADDR_THR_T);
        thr_if.data = reg_wdata;
        clp_if.wr   = reg_wr && (reg_addr >= APC_ADDR_CLP_T) && (reg_addr <= APC_ADDR_CLP_B);
        clp_if.sel  = 2'(reg_addr - APC_ADDR_CLP_T);
        clp_if.data = reg_wdata;
    end

    apc_level_shadow u_thr (
        .clock (clock),
        .rst_b (rst_b),
        .lv    (thr_if.shadow)
    );

    apc_level_shadow u_clp (
        .clock (clock),
        .rst_b (rst_b),
        .lv    (clp_if.shadow)
    );

    // ********************************
    // Read mux
    // ********************************
    always_comb begin
        if (reg_addr == APC_ADDR_UV) begin
            rdata_next = hv_undervoltage_select_reg;
        end else if (reg_addr == APC_ADDR_SC4) begin
            rdata_next = state_control_four_reg;
        end else if (reg_addr == APC_ADDR_RATE) begin
            rdata_next = drc_attack_release_rate_reg;
        end else if (reg_addr == APC_ADDR_THR_T) begin
            rdata_next = thr_t_reg;
        end else if (reg_addr == APC_ADDR_THR_M) begin
            rdata_next = thr_m_reg;
        end else if (reg_addr == APC_ADDR_THR_B) begin
            rdata_next = thr_b_reg;
        end else if (reg_addr == APC_ADDR_CLP_T) begin
            rdata_next = clp_t_reg;
        end else if (reg_addr == APC_ADDR_CLP_M) begin
            rdata_next = clp_m_reg;
        end else if (reg_addr == APC_ADDR_CLP_B) begin
            rdata_next = clp_b_reg;
        end else begin
            rdata_next = 8'h00;
        end
        trip_next = trip_mv(hv_undervoltage_select_reg[2:0]);
    end

    // ********************************
    // Input synchronisers
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            below_s1_reg <= 1'b0;
            below_s2_reg <= 1'b0;
            rms_s1_reg   <= 1'b0;
            rms_s2_reg   <= 1'b0;
        end else begin
            below_s1_reg <= power_stage_below_trip;
            below_s2_reg <= below_s1_reg;
            rms_s1_reg   <= input_rms_above;
            rms_s2_reg   <= rms_s1_reg;
        end
    end

    // ********************************
    // Under-voltage fade then cut
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            uv_state_reg <= APC_UV_IDLE;
            fade_cnt_reg <= 4'h0;
        end else begin
            case (uv_state_reg)
                APC_UV_IDLE: begin
                    fade_cnt_reg <= 4'h0;
                    if (!hv_undervoltage_select_reg[APC_UV_DIS_BIT] && below_s2_reg) begin
                        uv_state_reg <= APC_UV_FADE;
                    end
                end
                APC_UV_FADE: begin
                    fade_cnt_reg <= fade_cnt_reg + 4'h1;
                    if (hv_undervoltage_select_reg[APC_UV_DIS_BIT] || !below_s2_reg) begin
                        uv_state_reg <= APC_UV_IDLE;
                    end else if (fade_cnt_reg == APC_FADE_LAST) begin
                        uv_state_reg <= APC_UV_OFF;
                    end
                end
                APC_UV_OFF: begin
                    if (hv_undervoltage_select_reg[APC_UV_DIS_BIT] || !below_s2_reg) begin
                        uv_state_reg <= APC_UV_IDLE;
                    end
                end
                default: uv_state_reg <= APC_UV_IDLE;
            endcase
        end
    end

    // ********************************
    // Registered outputs
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reg_rdata              <= 8'h00;
            power_stage_uv_enable  <= !APC_UV_RST[APC_UV_DIS_BIT];
            power_stage_trip_mv    <= APC_TRIP_MV0;
            power_stage_uv_cut     <= 1'b0;
            low_supply_fade_off    <= 1'b0;
            over_supply_fade_off   <= 1'b0;
            ch1_mix_enable         <= 1'b0;
            ch2_mix_enable         <= 1'b0;
            ch1_clip_enable        <= 1'b0;
            ch2_clip_enable        <= 1'b0;
            ch1_power_limit_enable <= 1'b0;
            ch2_power_limit_enable <= 1'b0;
            mono_select            <= 1'b0;
            drc_attack_rate_code   <= 4'h0;
            drc_release_rate_code  <= 4'h0;
            drc_threshold          <= APC_UNITY;
            clip_level             <= APC_UNITY;
            drc_attack_active      <= 1'b0;
        end else begin
            reg_rdata              <= rdata_next;
            power_stage_uv_enable  <= !hv_undervoltage_select_reg[APC_UV_DIS_BIT];
            power_stage_trip_mv    <= trip_next;
            power_stage_uv_cut     <= (uv_state_reg == APC_UV_OFF);
            low_supply_fade_off    <= hv_undervoltage_select_reg[APC_LV_NOFADE_BIT];
            over_supply_fade_off   <= hv_undervoltage_select_reg[APC_OV_NOFADE_BIT];
            ch1_mix_enable         <= state_control_four_reg[APC_SC4_MIX1_BIT];
            ch2_mix_enable         <= state_control_four_reg[APC_SC4_MIX2_BIT];
            ch1_clip_enable        <= state_control_four_reg[APC_SC4_CLIP1_BIT];
            ch2_clip_enable        <= state_control_four_reg[APC_SC4_CLIP2_BIT];
            ch1_power_limit_enable <= state_control_four_reg[APC_SC4_LIM1_BIT];
            ch2_power_limit_enable <= state_control_four_reg[APC_SC4_LIM2_BIT];
            mono_select            <= state_control_four_reg[APC_SC4_MONO_BIT];
            drc_attack_rate_code   <= drc_attack_release_rate_reg[7:4];
            drc_release_rate_code  <= drc_attack_release_rate_reg[3:0];
            drc_threshold          <= thr_if.level;
            clip_level             <= clp_if.level;
            drc_attack_active      <= rms_s2_reg;
        end
    end
endmodule

/* File: testbench/apc_regs_assertions.sv */
`timescale 1ns/1ps
// ****
// Register bank port checks
// ****
module apc_regs_checker
    import apc_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        power_stage_uv_enable,
    input wire logic [15:0] power_stage_trip_mv,
    input wire logic        power_stage_uv_cut,
    input wire logic        low_supply_fade_off,
    input wire logic        over_supply_fade_off,
    input wire logic        ch1_mix_enable,
    input wire logic        ch2_mix_enable,
    input wire logic        ch1_clip_enable,
    input wire logic        ch1_power_limit_enable,
    input wire logic        mono_select,
    input wire logic        ch2_clip_enable,
    input wire logic        ch2_power_limit_enable,
    input wire logic [23:0] drc_threshold,
    input wire logic [23:0] clip_level,
    input wire logic        drc_attack_active,
    input wire logic        power_stage_below_trip,
    input wire logic        input_rms_above
);
    // Trip level per 3-bit code
    localparam logic [15:0] TRIP_TAB [8] = '{APC_TRIP_MV0, APC_TRIP_MV1, APC_TRIP_MV2,
        APC_TRIP_MV3, APC_TRIP_MV4, APC_TRIP_MV5, APC_TRIP_MV0, APC_TRIP_MV0};
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_uv_fields: assert property (
        reg_wr && reg_addr == APC_ADDR_UV |-> ##2 {power_stage_uv_enable, low_supply_fade_off,
        over_supply_fade_off} == {~$past(reg_wdata[7], 2), $past(reg_wdata[6:5], 2)})
        else $error("uv control outputs wrong");
    a_trip_decode: assert property (
        reg_wr && reg_addr == APC_ADDR_UV |-> ##2
        power_stage_trip_mv == TRIP_TAB[$past(reg_wdata[2:0], 2)])
        else $error("trip level decode wrong");
    a_sc4_fields: assert property (
        reg_wr && reg_addr == APC_ADDR_SC4 |-> ##2 {ch1_mix_enable, ch2_mix_enable,
        ch1_clip_enable, ch1_power_limit_enable, mono_select, ch2_clip_enable,
        ch2_power_limit_enable} == $past(reg_wdata[7:1], 2))
        else $error("state control outputs wrong");
    a_thr_bottom: assert property (
        reg_wr && reg_addr == APC_ADDR_THR_B |-> ##2 drc_threshold[7:0] == $past(reg_wdata, 2))
        else $error("threshold low byte wrong");
    a_thr_coherent: assert property (
        $changed(drc_threshold) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == APC_ADDR_THR_B)
        else $error("threshold changed without commit");
    a_clip_coherent: assert property (
        $changed(clip_level) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == APC_ADDR_CLP_B)
        else $error("clip level changed without commit");
    a_fade_first: assert property (
        $rose(power_stage_uv_cut) |-> $past(power_stage_below_trip, 16) && power_stage_uv_enable)
        else $error("drive cut without fade");
    a_drc_follow: assert property (
        $rose(input_rms_above) |-> ##[1:6] drc_attack_active)
        else $error("attack flag did not follow");
endmodule

bind apc_regs apc_regs_checker u_apc_chk (.*);

/* File: testbench/apc_host_model.sv */
`timescale 1ns/1ps
// Host side of the register port, one access at a time
module apc_host_model
    import apc_pkg::*;
(
    input  wire logic       clock,
    output logic            reg_wr,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Strobe held for one sampling edge
    task automatic host_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~v; // Stale data must not linger
    endtask
    // Address held until registered data settles
    task automatic host_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        v = reg_rdata;
    endtask
endmodule

/* File: testbench/tb_amp_protect_drc_clip_config.sv */
`timescale 1ns/1ps
module tb_amp_protect_drc_clip_config
    import apc_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_b;
    logic        power_stage_below_trip;
    logic        input_rms_above;
    logic        reg_wr;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, rd;
    logic        power_stage_uv_enable, power_stage_uv_cut, low_supply_fade_off;
    logic        over_supply_fade_off, ch1_mix_enable, ch2_mix_enable, ch1_clip_enable;
    logic        ch2_clip_enable, ch1_power_limit_enable, ch2_power_limit_enable;
    logic        mono_select, drc_attack_active;
    logic [3:0]  drc_attack_rate_code, drc_release_rate_code;
    logic [15:0] power_stage_trip_mv;
    logic [23:0] drc_threshold, clip_level;
    logic [6:0]  sc4_out;
    logic [2:0]  uv_out;
    int          fail_count = 0;
    int          comparisons = 0;
    localparam logic [15:0] TRIP_TAB [8] = '{APC_TRIP_MV0, APC_TRIP_MV1, APC_TRIP_MV2,
        APC_TRIP_MV3, APC_TRIP_MV4, APC_TRIP_MV5, APC_TRIP_MV0, APC_TRIP_MV0};
    localparam logic [7:0] RATE_PAT [3] = '{8'hF0, 8'h0F, 8'h5A};

    // Clock and design
    always #50 clock = ~clock;
    apc_regs DUT (.*);
    apc_host_model u_host (.*);
    // Output groups in register bit order
    assign sc4_out = {ch1_mix_enable, ch2_mix_enable, ch1_clip_enable, ch1_power_limit_enable,
                      mono_select, ch2_clip_enable, ch2_power_limit_enable};
    assign uv_out = {power_stage_uv_enable, low_supply_fade_off, over_supply_fade_off};

    // ****
    // Helpers
    // ****
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Outputs trail a write by two edges
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    // Bounded wait on cut (sel 0) or attack flag (sel 1)
    task automatic wait_bit(input logic sel, input logic lvl);
        int n;
        n = 0;
        while ((sel ? drc_attack_active : power_stage_uv_cut) !== lvl && n < 60) begin
            @(posedge clock);
            n++;
        end
        check(24'(sel ? drc_attack_active : power_stage_uv_cut), 24'(lvl));
        if (n == 60) begin
            fail_count++;
            test_done();
        end
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        rst_b = 1'b0;
        power_stage_below_trip = 1'b0;
        input_rms_above = 1'b0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check(24'(uv_out), 24'h4);
        check(24'(power_stage_trip_mv), 24'(TRIP_TAB[0]));
        check(drc_threshold, 24'h200000);
        check(clip_level, 24'h200000);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            d = {i[0], i[1], i[2], 2'b11, i[2:0]};
            u_host.host_write(APC_ADDR_UV, d);
            settle();
            check(24'(power_stage_trip_mv), 24'(TRIP_TAB[i]));
            check(24'(uv_out), 24'({~d[7], d[6:5]}));
            u_host.host_read(APC_ADDR_UV, rd);
            check(24'(rd), 24'(d & 8'hE7));
        end
        $display("supply select done");
        for (int i = 0; i < 8; i++) begin
            d = 8'h01 << i;
            if (i == APC_SC4_MONO_BIT) begin
                // Mono side registers sit outside this bank; values arbitrary
                u_host.host_write(8'h2E, 8'h00);
                u_host.host_write(8'h2F, 8'h00);
            end
            u_host.host_write(APC_ADDR_SC4, d);
            settle();
            check(24'(sc4_out), 24'(d[7:1]));
            u_host.host_read(APC_ADDR_SC4, rd);
            check(24'(rd), 24'(d & 8'hFE));
        end
        $display("state control done");
        foreach (RATE_PAT[i]) begin
            u_host.host_write(APC_ADDR_RATE, RATE_PAT[i]);
            settle();
            check(24'({drc_attack_rate_code, drc_release_rate_code}), 24'(RATE_PAT[i]));
        end
        $display("rate codes done");
        u_host.host_write(APC_ADDR_THR_T, 8'h10);
        u_host.host_write(APC_ADDR_THR_M, 8'h00);
        settle();
        check(drc_threshold, 24'h200000);
        u_host.host_write(APC_ADDR_THR_B, 8'h00);
        settle();
        check(drc_threshold, 24'h100000);
        u_host.host_write(APC_ADDR_CLP_T, 8'h16);
        u_host.host_write(APC_ADDR_CLP_M, 8'h9F);
        settle();
        check(clip_level, 24'h200000);
        u_host.host_write(APC_ADDR_CLP_B, 8'hB8);
        settle();
        check(clip_level, 24'h169FB8);
        // Mono side register is not held here, so it reads back empty
        u_host.host_write(8'h2E, 8'h55);
        u_host.host_read(8'h2E, rd);
        check(24'(rd), 24'h0);
        $display("levels done");
        // Higher trip level (8.2 V) chosen by the host for a low supply
        u_host.host_write(APC_ADDR_UV, 8'h01);
        @(posedge clock);
        power_stage_below_trip <= 1'b1;
        repeat (10) @(posedge clock);
        check(24'(power_stage_uv_cut), 24'h0);
        wait_bit(1'b0, 1'b1);
        u_host.host_write(APC_ADDR_UV, 8'h81);
        wait_bit(1'b0, 1'b0);
        power_stage_below_trip <= 1'b0;
        $display("supply cut done");
        @(posedge clock);
        input_rms_above <= 1'b1;
        wait_bit(1'b1, 1'b1);
        input_rms_above <= 1'b0;
        wait_bit(1'b1, 1'b0);
        $display("attack flag done");
        test_done();
    end
endmodule
